/* dcs_snoop_ctl.sv */
// What this block does
// [RULE1] Translation off: attributes forced to 0011
// [RULE2] Instruction block-translation pairs never guarded
// [RULE3] Coherent attribute selects global or local access
// [RULE4] Guarded locations: no speculative loads or prefetch
// [RULE5] Write-through/inhibited bits steer allocate and write-through
// [RULE6] Set from A[20-26], tag compare PA[0-19]
// [RULE7] No match is miss; match returns state
// [RULE8] Each 32-byte block holds two state bits
// [RULE9] Modified: resident, dirty, held nowhere else
// [RULE10] Exclusive: resident, sole owner, equals memory
// [RULE11] Invalid: no valid data or absent
// [RULE12] Every fill goes out as read-with-intent-to-modify
// [RULE13] Filled block exclusive; stores need no broadcast
// [RULE14] Snooped hit: push modified, then invalidate
// [RULE15] Inhibited snooped read never invalidates the block
// [RULE16] Inhibited read on modified: push, become exclusive
// [RULE17] Inhibited read on exclusive: nothing happens
// [RULE18] Snoops touch only the data directory
// [RULE19] Snoop only when start and global coincide
// [RULE20] Snoop wins tags; access goes next clock (here it waits until the push ends when the snoop hits a modified block)
// [RULE21] Snoop during tag write is retried
// [RULE22] Own castouts and pushes never marked global
// [RULE23] Fixed state encoding for lookup and update
module dcs_snoop_ctl #(
  parameter int WAYS = 8,
  parameter logic [4:0] TT_FILL = dcs_pkg::TT_FILL_DEF,
  parameter logic [4:0] TT_PUSH = dcs_pkg::TT_PUSH_DEF
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic acc_req,
  input wire logic acc_is_instr,
  input wire logic acc_is_store,
  input wire logic [31:0] acc_ea,
  input wire logic [31:0] acc_pa,
  input wire logic instr_translate_on,
  input wire logic data_translate_on,
  input wire logic [3:0] page_attribute_nibble,
  input wire logic instr_block_translation_pair,
  output logic acc_ready,
  output logic acc_done,
  output logic acc_hit,
  output logic [1:0] acc_state,
  output logic [3:0] acc_attr,
  output logic acc_global,
  output logic acc_allocate,
  output logic acc_write_through,
  output logic acc_speculate_ok,
  input wire logic transfer_start_strobe_n,
  input wire logic global_access_n,
  input wire logic [31:0] snoop_addr,
  input wire logic [4:0] transfer_type_code,
  output logic snoop_retry,
  output logic bus_req,
  output logic [31:0] bus_addr,
  output logic [4:0] bus_tt,
  output logic bus_global_n,
  input wire logic bus_done
);

  localparam int WB = (WAYS > 1) ? $clog2(WAYS) : 1;

  // Bus requests always name the start of a block
  localparam logic [dcs_pkg::BLK_OFS_W-1:0] BLK_ZERO = '0;

  typedef dcs_pkg::dcs_entry_t [dcs_pkg::NSETS-1:0][WAYS-1:0] dcs_dir_t;

  typedef struct packed {
    dcs_dir_t dir;
    dcs_pkg::dcs_fsm_t fsm;
    logic [dcs_pkg::IDX_W-1:0] op_idx;
    logic [dcs_pkg::TAG_W-1:0] op_tag;
    logic [WB-1:0] op_way;
    logic [1:0] push_next;
    logic [WB-1:0] victim;
    logic bus_req;
    logic [31:0] bus_addr;
    logic [4:0] bus_tt;
    logic bus_global_n;
    logic snoop_retry;
    logic acc_done;
    logic acc_hit;
    logic [1:0] acc_state;
    logic [3:0] acc_attr;
    logic acc_global;
    logic acc_allocate;
    logic acc_write_through;
    logic acc_speculate_ok;
    logic [31:0] ctrl;
    logic [31:0] snoop_hits;
    logic [31:0] retries;
    logic [1:0] last_snp_st;
    logic last_snp_hit;
    logic ack;
    logic [31:0] rdata;
  } dcs_state_t;

  dcs_state_t s_q;
  dcs_state_t s_d;

  typedef struct packed {
    logic hit;
    logic [WB-1:0] way;
    logic [1:0] st;
  } dcs_look_t;

  // A matching tag whose state is invalid counts as absent
  function automatic dcs_look_t lookup(input dcs_dir_t d, input logic [dcs_pkg::IDX_W-1:0] idx,
                                       input logic [dcs_pkg::TAG_W-1:0] tag);
    dcs_look_t r;
    r = '0;
    r.st = dcs_pkg::ST_INV;
    for (int w = 0; w < WAYS; w++) begin
      if (!r.hit && d[idx][w].st != dcs_pkg::ST_INV && d[idx][w].tag == tag) begin // [RULE6] [RULE7] [RULE11]
        r.hit = 1'b1;
        r.way = WB'(w);
        r.st = d[idx][w].st; // [RULE23]
      end
    end
    return r;
  endfunction

  logic snoop_qual;
  logic snoop_take;
  dcs_look_t snp_look;
  dcs_look_t acc_look;
  logic [3:0] attr;
  logic snp_ci;
  logic [dcs_pkg::IDX_W-1:0] snp_idx;
  logic [dcs_pkg::IDX_W-1:0] acc_idx;
  logic [WB-1:0] fill_way;
  logic fill_found;
  logic [dcs_pkg::TAG_W-1:0] snp_tag;
  logic [dcs_pkg::TAG_W-1:0] acc_tag;
  logic [31:0] snp_blk;
  logic [31:0] acc_blk;

  always_comb begin
    snoop_qual = !transfer_start_strobe_n && !global_access_n && !s_q.ctrl[dcs_pkg::CTRL_SNOOP_OFF]; // [RULE19]
    snoop_take = snoop_qual && s_q.fsm == dcs_pkg::FSM_IDLE;
    snp_idx = snoop_addr[dcs_pkg::IDX_HI:dcs_pkg::IDX_LO];
    acc_idx = acc_ea[dcs_pkg::IDX_HI:dcs_pkg::IDX_LO]; // [RULE6]
    snp_tag = snoop_addr[dcs_pkg::TAG_HI:dcs_pkg::TAG_LO];
    acc_tag = acc_pa[dcs_pkg::TAG_HI:dcs_pkg::TAG_LO]; // [RULE6]
    snp_blk = {snp_tag, snp_idx, BLK_ZERO};
    acc_blk = {acc_tag, acc_idx, BLK_ZERO};
    snp_look = lookup(s_q.dir, snp_idx, snp_tag);
    acc_look = lookup(s_q.dir, acc_idx, acc_tag);
    snp_ci = transfer_type_code[3:0] == dcs_pkg::TT_CI_READ_LOW; // [RULE15]
    if (acc_is_instr) begin
      if (instr_translate_on) begin
        attr = page_attribute_nibble;
        if (instr_block_translation_pair) begin
          attr[dcs_pkg::ATTR_G] = 1'b0; // [RULE2]
        end
      end else begin
        attr = dcs_pkg::REAL_MODE_ATTR; // [RULE1]
      end
    end else if (data_translate_on) begin
      attr = page_attribute_nibble;
    end else begin
      attr = dcs_pkg::REAL_MODE_ATTR; // [RULE1]
    end
    fill_way = s_q.victim;
    fill_found = 1'b0;
    for (int w = 0; w < WAYS; w++) begin
      if (!fill_found && s_q.dir[s_q.op_idx][w].st == dcs_pkg::ST_INV) begin
        fill_found = 1'b1;
        fill_way = WB'(w);
      end
    end
  end

  // Snoop owns the single-ported tags this cycle, so the access waits
  assign acc_ready = acc_req && s_q.fsm == dcs_pkg::FSM_IDLE && !snoop_qual; // [RULE20]
  assign avs_waitrequest = (avs_read || avs_write) && !s_q.ack;

  always_comb begin
    s_d = s_q;
    s_d.acc_done = 1'b0;
    s_d.snoop_retry = 1'b0;

    // Register slave: one wait cycle, then the answer
    s_d.ack = 1'b0;
    if ((avs_read || avs_write) && !s_q.ack) begin
      s_d.ack = 1'b1;
      s_d.rdata = '0;
      if (avs_read) begin
        unique case (avs_address)
          dcs_pkg::REG_CTRL: begin
            s_d.rdata = s_q.ctrl;
          end
          dcs_pkg::REG_STATUS: begin
            s_d.rdata[dcs_pkg::STAT_FSM_LO +: 2] = s_q.fsm;
            s_d.rdata[dcs_pkg::STAT_SNP_ST_LO +: 2] = s_q.last_snp_st;
            s_d.rdata[dcs_pkg::STAT_SNP_HIT] = s_q.last_snp_hit;
          end
          dcs_pkg::REG_SNOOP_HITS: begin
            s_d.rdata = s_q.snoop_hits;
          end
          dcs_pkg::REG_RETRIES: begin
            s_d.rdata = s_q.retries;
          end
          default: begin
            s_d.rdata = '0;
          end
        endcase
      end
    end

    // A write lands on the answering edge only, so a stalled master never writes twice
    if (avs_write && s_q.ack) begin
      unique case (avs_address)
        dcs_pkg::REG_CTRL: begin
          s_d.ctrl = avs_writedata;
        end
        dcs_pkg::REG_SNOOP_HITS: begin
          s_d.snoop_hits = '0;
        end
        dcs_pkg::REG_RETRIES: begin
          s_d.retries = '0;
        end
        default: begin
          s_d.ctrl = s_q.ctrl;
        end
      endcase
    end

    // Busy with a fill or push: includes the tag write at fill completion
    if (snoop_qual && s_q.fsm != dcs_pkg::FSM_IDLE) begin
      s_d.snoop_retry = 1'b1; // [RULE21]
      s_d.retries = s_d.retries + 32'h1;
    end

    unique case (s_q.fsm)
      dcs_pkg::FSM_IDLE: begin
        if (snoop_take) begin
          s_d.last_snp_hit = snp_look.hit;
          s_d.last_snp_st = snp_look.st;
          // Only the data directory is searched; no instruction tags exist here
          if (snp_look.hit) begin // [RULE18]
            s_d.snoop_hits = s_d.snoop_hits + 32'h1;
            if (snp_look.st == dcs_pkg::ST_MOD) begin // [RULE9]
              // Requester is retried and comes back after the push lands
              s_d.snoop_retry = 1'b1;
              s_d.fsm = dcs_pkg::FSM_PUSH;
              s_d.op_idx = snp_idx;
              s_d.op_way = snp_look.way;
              if (snp_ci) begin
                s_d.push_next = dcs_pkg::ST_EXC; // [RULE16]
              end else begin
                s_d.push_next = dcs_pkg::ST_INV; // [RULE14]
              end
              s_d.bus_req = 1'b1;
              s_d.bus_addr = snp_blk;
              s_d.bus_tt = TT_PUSH;
              s_d.bus_global_n = 1'b1; // [RULE22]
            end else if (!snp_ci) begin
              s_d.dir[snp_idx][snp_look.way].st = dcs_pkg::ST_INV; // [RULE14] [RULE10]
            end
            // Exclusive block under an inhibited read stays as it is [RULE17]
          end
        end else if (acc_ready) begin
          s_d.acc_done = 1'b1;
          s_d.acc_attr = attr;
          s_d.acc_global = attr[dcs_pkg::ATTR_M]; // [RULE3]
          s_d.acc_speculate_ok = !attr[dcs_pkg::ATTR_G]; // [RULE4]
          s_d.acc_write_through = attr[dcs_pkg::ATTR_W]; // [RULE5]
          s_d.acc_allocate = !attr[dcs_pkg::ATTR_I] && !acc_is_instr; // [RULE5]
          s_d.acc_hit = !acc_is_instr && acc_look.hit; // [RULE7]
          if (acc_is_instr) begin
            s_d.acc_state = dcs_pkg::ST_INV;
          end else begin
            s_d.acc_state = acc_look.st;
          end
          if (!acc_is_instr && !attr[dcs_pkg::ATTR_I]) begin
            if (acc_look.hit) begin
              // Write-through store to a modified block leaves it modified
              if (acc_is_store && !attr[dcs_pkg::ATTR_W] && acc_look.st == dcs_pkg::ST_EXC) begin
                s_d.dir[acc_idx][acc_look.way].st = dcs_pkg::ST_MOD; // [RULE13] [RULE9]
              end
            end else begin
              s_d.fsm = dcs_pkg::FSM_FILL;
              s_d.op_idx = acc_idx;
              s_d.op_tag = acc_tag;
              s_d.bus_req = 1'b1;
              s_d.bus_addr = acc_blk;
              s_d.bus_tt = TT_FILL; // [RULE12]
              s_d.bus_global_n = !attr[dcs_pkg::ATTR_M]; // [RULE3]
            end
          end
        end
      end
      dcs_pkg::FSM_FILL: begin
        if (bus_done) begin
          s_d.dir[s_q.op_idx][fill_way].tag = s_q.op_tag; // [RULE8]
          s_d.dir[s_q.op_idx][fill_way].st = dcs_pkg::ST_EXC; // [RULE13]
          s_d.victim = s_q.victim + WB'(1);
          s_d.bus_req = 1'b0;
          s_d.bus_global_n = 1'b1;
          s_d.fsm = dcs_pkg::FSM_IDLE;
        end
      end
      dcs_pkg::FSM_PUSH: begin
        if (bus_done) begin
          s_d.dir[s_q.op_idx][s_q.op_way].st = s_q.push_next; // [RULE14] [RULE16]
          s_d.bus_req = 1'b0;
          s_d.fsm = dcs_pkg::FSM_IDLE;
        end
      end
      default: begin
        s_d.fsm = dcs_pkg::FSM_IDLE;
        s_d.bus_req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.ctrl <= dcs_pkg::CTRL_RESET;
      s_q.bus_global_n <= 1'b1;
      s_q.acc_speculate_ok <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata = s_q.rdata;
  assign acc_done = s_q.acc_done;
  assign acc_hit = s_q.acc_hit;
  assign acc_state = s_q.acc_state;
  assign acc_attr = s_q.acc_attr;
  assign acc_global = s_q.acc_global;
  assign acc_allocate = s_q.acc_allocate;
  assign acc_write_through = s_q.acc_write_through;
  assign acc_speculate_ok = s_q.acc_speculate_ok;
  assign snoop_retry = s_q.snoop_retry;
  assign bus_req = s_q.bus_req;
  assign bus_addr = s_q.bus_addr;
  assign bus_tt = s_q.bus_tt;
  assign bus_global_n = s_q.bus_global_n;

endmodule

/* dcs_pkg.sv */
package dcs_pkg;

  // Address slicing (bit 0 is the least significant bit)
  localparam int IDX_LO = 5;
  localparam int IDX_HI = 11;
  localparam int TAG_LO = 12;
  localparam int TAG_HI = 31;
  localparam int IDX_W = IDX_HI - IDX_LO + 1;
  localparam int TAG_W = TAG_HI - TAG_LO + 1;
  localparam int NSETS = 1 << IDX_W;
  localparam int BLK_OFS_W = IDX_LO;

  // Coherency state codes, shared by lookup and update
  localparam logic [1:0] ST_INV = 2'h0;
  localparam logic [1:0] ST_EXC = 2'h1;
  localparam logic [1:0] ST_MOD = 2'h3;

  // Page attribute nibble: write-through, inhibited, coherent, guarded
  localparam int ATTR_W = 3;
  localparam int ATTR_I = 2;
  localparam int ATTR_M = 1;
  localparam int ATTR_G = 0;
  localparam logic [3:0] REAL_MODE_ATTR = 4'h3;

  // Low four bits of a caching-inhibited read transfer type (top bit ignored)
  localparam logic [3:0] TT_CI_READ_LOW = 4'ha;

  // Default transfer type codes for our own bus requests
  localparam logic [4:0] TT_FILL_DEF = 5'h0e;
  localparam logic [4:0] TT_PUSH_DEF = 5'h06;

  // Register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_SNOOP_HITS = 4'h8;
  localparam logic [3:0] REG_RETRIES = 4'hc;
  localparam int CTRL_SNOOP_OFF = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0;
  localparam int STAT_FSM_LO = 0;
  localparam int STAT_SNP_ST_LO = 4;
  localparam int STAT_SNP_HIT = 8;

  typedef enum logic [1:0] {
    FSM_IDLE = 2'h0,
    FSM_FILL = 2'h1,
    FSM_PUSH = 2'h3
  } dcs_fsm_t;

  typedef struct packed {
    logic [TAG_W-1:0] tag;
    logic [1:0] st;
  } dcs_entry_t;

endpackage

/* dcs_snoop_ctl_asserts.sv */
module dcs_snoop_ctl_asserts #(
  parameter logic [4:0] TT_FILL = dcs_pkg::TT_FILL_DEF,
  parameter logic [4:0] TT_PUSH = dcs_pkg::TT_PUSH_DEF
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic acc_req,
  input wire logic acc_is_instr,
  input wire logic instr_translate_on,
  input wire logic data_translate_on,
  input wire logic instr_block_translation_pair,
  input wire logic acc_ready,
  input wire logic acc_done,
  input wire logic [3:0] acc_attr,
  input wire logic acc_global,
  input wire logic acc_allocate,
  input wire logic acc_speculate_ok,
  input wire logic transfer_start_strobe_n,
  input wire logic global_access_n,
  input wire logic snoop_retry,
  input wire logic bus_req,
  input wire logic [4:0] bus_tt,
  input wire logic bus_global_n,
  input wire logic bus_done
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_take;
    acc_req && acc_ready;
  endsequence
  sequence s_snoop;
    !transfer_start_strobe_n && !global_access_n;
  endsequence
  AST_DONE_NEXT: assert property (s_take |=> acc_done) else $error("access result missing");
  AST_SNOOP_FIRST: assert property (s_snoop |-> !acc_ready) else $error("access beat a snoop");
  AST_REAL_MODE: assert property (s_take ##0 (acc_is_instr ? !instr_translate_on : !data_translate_on)
    |=> acc_attr == 4'h3) else $error("real mode attributes wrong");
  AST_INSTR_PAIR: assert property (s_take ##0 (acc_is_instr && instr_translate_on && instr_block_translation_pair)
    |=> !acc_attr[dcs_pkg::ATTR_G]) else $error("pair access guarded");
  AST_GLOBAL_M: assert property (s_take ##0 !acc_is_instr |=> acc_global == acc_attr[dcs_pkg::ATTR_M])
    else $error("global does not follow coherence bit");
  AST_GUARD_SPEC: assert property (acc_done && acc_attr[dcs_pkg::ATTR_G] |-> !acc_speculate_ok)
    else $error("guarded access speculated");
  AST_INHIBIT: assert property (acc_done && acc_attr[dcs_pkg::ATTR_I] |-> !acc_allocate)
    else $error("inhibited access allocates");
  AST_FILL_CODE: assert property (bus_req && bus_tt != TT_PUSH |-> bus_tt == TT_FILL)
    else $error("fill not sent as intent to modify");
  AST_PUSH_LOCAL: assert property (bus_req && bus_tt == TT_PUSH |-> bus_global_n)
    else $error("push marked global");
  AST_BUSY_RETRY: assert property (s_snoop ##0 (bus_req && !bus_done) |=> snoop_retry)
    else $error("snoop during busy not retried");
  AST_BUS_HOLD: assert property (bus_req && !bus_done |=> bus_req && $stable(bus_tt))
    else $error("bus request dropped early");
endmodule

bind dcs_snoop_ctl dcs_snoop_ctl_asserts #(.TT_FILL(TT_FILL), .TT_PUSH(TT_PUSH)) u_chk (.*);

/* dcs_bus_model.sv */
module dcs_bus_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic bus_req,
  input wire logic [3:0] dly,
  output logic bus_done
);
  logic [3:0] cnt_q;
  // Memory side ends each burst dly+1 cycles after it sees bus_req, with a one-cycle pulse
  always_ff @(posedge ref_clk) begin
    if (!nrst || !bus_req || bus_done) begin
      cnt_q <= 4'h0;
      bus_done <= 1'b0;
    end else if (cnt_q == dly) begin
      bus_done <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

/* tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, nrst, avs_read, avs_write, acc_req, acc_is_instr, acc_is_store, instr_translate_on;
  logic data_translate_on, instr_block_translation_pair, acc_ready, acc_done, acc_hit, acc_global, acc_allocate;
  logic acc_write_through, acc_speculate_ok, transfer_start_strobe_n, global_access_n, snoop_retry;
  logic bus_req, bus_global_n, bus_done, avs_waitrequest;
  logic [3:0] avs_address, page_attribute_nibble, acc_attr, dly, at;
  logic [1:0] acc_state;
  logic [4:0] transfer_type_code, bus_tt, k;
  logic [31:0] avs_writedata, avs_readdata, acc_ea, acc_pa, snoop_addr, bus_addr, rd;
  int n_fail, checks_done;
  localparam logic [31:0] BLK_A = 32'h00012040;

  dcs_snoop_ctl uut (.*);
  dcs_bus_model u_mem (.ref_clk(ref_clk), .nrst(nrst), .bus_req(bus_req), .dly(dly), .bus_done(bus_done));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask

  task end_sim;
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task avs(input logic w, input logic [3:0] ad, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= ad;
    avs_writedata <= d;
    n = 0;
    do begin @(posedge ref_clk); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // k = {instr, store, instr xlate, data xlate, instr pair}
  task acc(input logic [4:0] kk, input logic [3:0] aa, input logic [31:0] a);
    int n;
    logic [3:0] e;
    @(posedge ref_clk);
    {acc_is_instr, acc_is_store, instr_translate_on, data_translate_on, instr_block_translation_pair} <= kk;
    page_attribute_nibble <= aa;
    acc_ea <= a;
    acc_pa <= a;
    acc_req <= 1'b1;
    n = 0;
    do begin @(posedge ref_clk); n++; end while (acc_ready !== 1'b1 && n < 500);
    acc_req <= 1'b0;
    acc_ea <= ~a;
    @(posedge ref_clk);
    e = (kk[4] ? !kk[2] : !kk[1]) ? 4'h3 : ((kk[4] && kk[0]) ? (aa & 4'he) : aa);
    chk("done", 1, acc_done);
    chk("attr", e, acc_attr);
    chk("spec", !e[0], acc_speculate_ok);
    chk("wthru", e[3], acc_write_through);
    chk("alloc", !e[2] && !kk[4], acc_allocate);
    if (!kk[4]) chk("glob", e[1], acc_global);
  endtask

  // Inhibited lookups report state without touching the directory
  task probe(input logic [31:0] a, input logic h, input logic [1:0] s, input string nm);
    acc(5'h06, 4'h6, a);
    chk(nm, {h, s}, {acc_hit, acc_state});
  endtask

  task snp(input logic g, input logic [4:0] tt, input logic [31:0] a);
    @(posedge ref_clk);
    transfer_start_strobe_n <= 1'b0;
    global_access_n <= !g;
    snoop_addr <= a;
    transfer_type_code <= tt;
    @(posedge ref_clk);
    transfer_start_strobe_n <= 1'b1;
    global_access_n <= 1'b1;
    snoop_addr <= ~a;
    transfer_type_code <= ~tt;
    @(posedge ref_clk);
  endtask

  task drain;
    int n;
    n = 0;
    while (bus_req !== 1'b0 && n < 100) begin @(posedge ref_clk); n++; end
    chk("drain", 0, bus_req);
  endtask

  initial begin
    nrst = 1'b0;
    {avs_read, avs_write, acc_req, acc_is_instr, acc_is_store, instr_block_translation_pair} = '0;
    {instr_translate_on, data_translate_on, transfer_start_strobe_n, global_access_n} = 4'hf;
    {avs_address, page_attribute_nibble, transfer_type_code, dly} = '0;
    {avs_writedata, acc_ea, acc_pa, snoop_addr} = '0;
    n_fail = 0;
    checks_done = 0;
    rd = $urandom(24);
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    chk("rst", 2'h1, {acc_done, bus_global_n});
    avs(1'b1, 4'h3, 32'hffffffff);
    avs(1'b0, dcs_pkg::REG_CTRL, 32'h0);
    chk("ctrl", 0, rd);
    avs(1'b0, 4'h2, 32'h0);
    chk("unmapped", 0, rd);
    probe(BLK_A, 1'b0, dcs_pkg::ST_INV, "miss");
    dly <= 4'h9;
    acc(5'h06, 4'h2, BLK_A);
    chk("fill", {1'b1, dcs_pkg::TT_FILL_DEF, 1'b0}, {bus_req, bus_tt, bus_global_n});
    chk("fill_addr", {BLK_A[31:5], 5'h00}, bus_addr);
    snp(1'b1, 5'h02, 32'h00345060);
    chk("busy", 1, snoop_retry);
    drain;
    probe(BLK_A | 32'h1f, 1'b1, dcs_pkg::ST_EXC, "filled");
    probe(BLK_A ^ 32'h00001000, 1'b0, dcs_pkg::ST_INV, "tag");
    probe(BLK_A ^ 32'h00000020, 1'b0, dcs_pkg::ST_INV, "set");
    acc(5'h0e, 4'h2, BLK_A);
    chk("nobcast", 0, bus_req);
    probe(BLK_A, 1'b1, dcs_pkg::ST_MOD, "stored");
    snp(1'b0, 5'h02, BLK_A);
    probe(BLK_A, 1'b1, dcs_pkg::ST_MOD, "local");
    snp(1'b1, 5'h1a, BLK_A);
    chk("ci_push", {2'h3, dcs_pkg::TT_PUSH_DEF, 1'b1}, {snoop_retry, bus_req, bus_tt, bus_global_n});
    drain;
    probe(BLK_A, 1'b1, dcs_pkg::ST_EXC, "ci_mod");
    snp(1'b1, 5'h0a, BLK_A);
    chk("ci_exc", 0, {snoop_retry, bus_req});
    probe(BLK_A, 1'b1, dcs_pkg::ST_EXC, "ci_exc_st");
    avs(1'b0, dcs_pkg::REG_STATUS, 32'h0);
    chk("stat_hit", 1, rd[dcs_pkg::STAT_SNP_HIT]);
    for (int i = 0; i < 2; i++) begin
      if (i == 1) acc(5'h06, 4'h2, BLK_A);
      drain;
      if (i == 1) acc(5'h0e, 4'h2, BLK_A);
      snp(1'b1, 5'h02, BLK_A);
      chk("push", i, bus_req);
      drain;
      probe(BLK_A, 1'b0, dcs_pkg::ST_INV, "flushed");
    end
    acc(5'h16, 4'h2, BLK_A);
    chk("ifetch", 0, bus_req);
    fork
      acc(5'h06, 4'h6, 32'h00000400);
      snp(1'b1, 5'h02, 32'h00000800);
    join
    for (int i = 0; i < 40; i++) begin
      k = 5'($urandom);
      at = 4'($urandom);
      dly <= 4'($urandom % 8);
      acc(k, at, $urandom);
      drain;
    end
    end_sim;
  end

  initial begin
    repeat (30000) @(posedge ref_clk);
    n_fail++;
    end_sim;
  end
endmodule
